// File: design/spau_core.sv
/*
  Stack pointer address unit: push/pop sequencing, pointer width
  selection, call/return linking, APB register access.
  Assumes a stack memory that holds mem_req until it pulses mem_ack.
*/
`timescale 1ns/1ns

// Operation
// - Push: decrement pointer, then write memory
// - Pop: read memory, then increment pointer
// - Stack segment may span 4 GBytes
// - Stack accesses use stack segment base
// - Step size follows code default flag
// - Selector push aligns to 32-bit boundary
// - 16-bit push on wide stack steps two
// - No alignment check, no fault
// - Explicit address size: flag xor prefix
// - 16-bit or 32-bit pointer by size
// - Big flag selects default stack size
// - Frame base references use stack segment
// - Call pushes return pointer before branching
// - Return pops instruction pointer
// - Return pops wherever pointer now points
// - Popped return address never verified
// - 64-bit mode: zero base, descriptor ignored
// - 64-bit mode: descriptor privilege follows current
// - 64-bit mode: 64-bit pointers and steps
// - 64-bit mode: selector push takes full slot
// - 64-bit mode: some segment loads invalid
// - One command loads selector and pointer
module spau_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stack memory
  output spau_pkg::spau_mem_s mem_req,
  input wire logic [63:0] mem_rdata,
  input wire logic mem_ack
);
  import spau_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEC, ST_WR, ST_ISS, ST_RD, ST_INC
  } spau_st_e;

  spau_st_e st_q;
  spau_st_e st_d;
  spau_ctl_s ctl_q;
  spau_op_e op_q;
  logic op16_q;
  logic [63:0] stk_ptr_q;
  logic [63:0] instr_ptr_q;
  logic [63:0] frame_base_q;
  logic [63:0] dat_q;
  logic [15:0] sel_q;
  logic [1:0] desc_priv_q;
  logic [31:0] base_q;
  logic inv_q;
  spau_mem_s mem_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  ////////////////////////////////////////////////////////////////////
  // APB decode

  logic apb_setup;
  logic apb_wr;
  logic idle;
  logic hit;
  logic [31:0] rd_word;
  logic [31:0] stat_word;

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & pready_q;
  assign idle = (st_q == ST_IDLE);

  logic wr_ctrl, wr_cmd, wr_stat, wr_sel, wr_base;
  logic wr_ptr_lo, wr_ptr_hi, wr_ip_lo, wr_ip_hi;
  logic wr_fb_lo, wr_fb_hi, wr_dat_lo, wr_dat_hi;

  assign wr_ctrl = apb_wr & (paddr == OFS_CTRL);
  assign wr_cmd = apb_wr & (paddr == OFS_CMD);
  assign wr_stat = apb_wr & (paddr == OFS_STAT);
  assign wr_sel = apb_wr & (paddr == OFS_SEL) & idle;
  assign wr_base = apb_wr & (paddr == OFS_BASE) & idle;
  assign wr_ptr_lo = apb_wr & (paddr == OFS_PTR_LO) & idle;
  assign wr_ptr_hi = apb_wr & (paddr == OFS_PTR_HI) & idle;
  assign wr_ip_lo = apb_wr & (paddr == OFS_IP_LO) & idle;
  assign wr_ip_hi = apb_wr & (paddr == OFS_IP_HI) & idle;
  assign wr_fb_lo = apb_wr & (paddr == OFS_FB_LO) & idle;
  assign wr_fb_hi = apb_wr & (paddr == OFS_FB_HI) & idle;
  assign wr_dat_lo = apb_wr & (paddr == OFS_DAT_LO) & idle;
  assign wr_dat_hi = apb_wr & (paddr == OFS_DAT_HI) & idle;

  assign stat_word = {27'h0, desc_priv_q,
                      ctl_q.code_d ^ ctl_q.pfx,
                      inv_q, ~idle};

  assign hit = (paddr <= OFS_ADR) & (paddr[1:0] == 2'h0);

  assign rd_word =
    (paddr == OFS_CTRL) ? {26'h0, ctl_q} :
    (paddr == OFS_STAT) ? stat_word :
    (paddr == OFS_PTR_LO) ? stk_ptr_q[31:0] :
    (paddr == OFS_PTR_HI) ? stk_ptr_q[63:32] :
    (paddr == OFS_IP_LO) ? instr_ptr_q[31:0] :
    (paddr == OFS_IP_HI) ? instr_ptr_q[63:32] :
    (paddr == OFS_FB_LO) ? frame_base_q[31:0] :
    (paddr == OFS_FB_HI) ? frame_base_q[63:32] :
    (paddr == OFS_DAT_LO) ? dat_q[31:0] :
    (paddr == OFS_DAT_HI) ? dat_q[63:32] :
    (paddr == OFS_SEL) ? {14'h0, desc_priv_q, sel_q} :
    (paddr == OFS_BASE) ? base_q :
    (paddr == OFS_ADR) ? mem_q.addr[31:0] : 32'h0;

  // No wait state: data is registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~hit;
      prdata_q <= apb_setup ? rd_word : 32'h0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////
  // Command decode

  spau_op_e cmd_op;
  logic start, bad_lm, inv_set, go_push, go_read, go_ld;

  assign cmd_op = spau_op_e'(pwdata[CMD_OP_MSB:0]);
  assign start = wr_cmd & idle;
  assign bad_lm = ctl_q.lm & ((cmd_op == OP_LD_FAR_DATA) |
                              (cmd_op == OP_POP_EXTRA));
  assign inv_set = start & bad_lm;
  assign go_push = start & ~bad_lm & ((cmd_op == OP_PUSH) |
    (cmd_op == OP_PUSH_SEG) | (cmd_op == OP_CALL));
  assign go_read = start & ~bad_lm & ((cmd_op == OP_POP) |
    (cmd_op == OP_RET) | (cmd_op == OP_POP_EXTRA) |
    (cmd_op == OP_FRAME_RD) | (cmd_op == OP_PTR_RD));
  assign go_ld = start & (cmd_op == OP_LD_FAR_STACK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= OP_NONE;
      op16_q <= 1'b0;
    end else if (start) begin
      op_q <= cmd_op;
      op16_q <= pwdata[CMD_OP16];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pointer arithmetic

  logic is_seg, is_pop, is_call, is_ret;
  logic [63:0] step, ptr_off, top_off, dec_raw, dec_val, inc_val;
  logic [63:0] ptr_push, ptr_pop, push_val, pop_val;

  assign is_seg = (op_q == OP_PUSH_SEG);
  assign is_call = (op_q == OP_CALL);
  assign is_ret = (op_q == OP_RET);
  assign is_pop = is_ret | (op_q == OP_POP) | (op_q == OP_POP_EXTRA);

  // A plain 16-bit value on a wide stack may misalign it
  assign step = ctl_q.lm ? STEP_Q :
    (ctl_q.code_d & ~(op16_q & ~is_seg)) ? STEP_D :
    STEP_W;

  // Offset width chosen by the big flag, or 64 in long mode
  function automatic logic [63:0] spau_off(input logic [63:0] v,
                                           input spau_ctl_s c);
    if (c.lm)
      return v;
    else if (c.ss_big)
      return {32'h0, v[31:0]};
    else
      return {48'h0, v[15:0]};
  endfunction

  // Keeps pointer bits above the active width
  function automatic logic [63:0] spau_merge(input logic [63:0] old_v,
                                             input logic [63:0] new_v,
                                             input spau_ctl_s c);
    if (c.lm)
      return new_v;
    else if (c.ss_big)
      return {old_v[63:32], new_v[31:0]};
    else
      return {old_v[63:16], new_v[15:0]};
  endfunction

  // Segment base applies outside long mode; 32-bit wrap spans 4 GB
  function automatic logic [63:0] spau_lin(input logic [63:0] off,
                                           input logic [31:0] b,
                                           input spau_ctl_s c);
    if (c.lm)
      return off;
    else
      return {32'h0, b + off[31:0]};
  endfunction

  assign ptr_off = spau_off(stk_ptr_q, ctl_q);
  assign top_off = (op_q == OP_FRAME_RD) ?
    spau_off(frame_base_q, ctl_q) : ptr_off;
  assign dec_raw = ptr_off - step;
  // Selector push lands on a whole slot; no fault if misaligned
  assign dec_val = is_seg ? (dec_raw & ~(step - 64'h1)) :
    dec_raw;
  assign inc_val = ptr_off + step;
  assign ptr_push = spau_merge(stk_ptr_q, dec_val, ctl_q);
  assign ptr_pop = spau_merge(stk_ptr_q, inc_val, ctl_q);

  assign push_val = is_seg ? {48'h0, sel_q} :
    is_call ? instr_ptr_q : dat_q;
  assign pop_val = ctl_q.lm ? mem_rdata :
    (step == STEP_D) ? {32'h0, mem_rdata[31:0]} :
    {48'h0, mem_rdata[15:0]};

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  logic ack;
  assign ack = mem_ack & mem_q.req;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (go_push)
          st_d = ST_DEC;
        else if (go_read)
          st_d = ST_ISS;
      end
      ST_DEC: st_d = ST_WR;
      ST_WR: begin
        if (ack)
          st_d = ST_IDLE;
      end
      ST_ISS: st_d = ST_RD;
      ST_RD: begin
        if (ack)
          st_d = is_pop ? ST_INC : ST_IDLE;
      end
      ST_INC: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  // Request is held until the memory acknowledges it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q <= '0;
    end else if (st_q == ST_DEC) begin
      mem_q.req <= 1'b1;
      mem_q.we <= 1'b1;
      mem_q.nbytes <= step[3:0];
      mem_q.addr <= spau_lin(spau_off(ptr_push, ctl_q), base_q, ctl_q);
      mem_q.wdata <= push_val;
    end else if (st_q == ST_ISS) begin
      mem_q.req <= 1'b1;
      mem_q.we <= 1'b0;
      mem_q.nbytes <= step[3:0];
      mem_q.addr <= spau_lin(top_off, base_q, ctl_q);
      mem_q.wdata <= 64'h0;
    end else if (ack) begin
      mem_q.req <= 1'b0;
    end
  end

  assign mem_req = mem_q;

  ////////////////////////////////////////////////////////////////////
  // Architectural state

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stk_ptr_q <= PTR_RST;
    else if (st_q == ST_DEC)
      stk_ptr_q <= ptr_push;
    else if (st_q == ST_INC)
      stk_ptr_q <= ptr_pop;
    else if (go_ld)
      stk_ptr_q <= spau_merge(stk_ptr_q, dat_q, ctl_q);
    else if (wr_ptr_lo)
      stk_ptr_q[31:0] <= pwdata;
    else if (wr_ptr_hi)
      stk_ptr_q[63:32] <= pwdata;
  end

  // Any value popped by a return is taken as the return target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      instr_ptr_q <= PTR_RST;
    else if ((st_q == ST_WR) & ack & is_call)
      instr_ptr_q <= dat_q;
    else if ((st_q == ST_RD) & ack & is_ret)
      instr_ptr_q <= pop_val;
    else if (wr_ip_lo)
      instr_ptr_q[31:0] <= pwdata;
    else if (wr_ip_hi)
      instr_ptr_q[63:32] <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dat_q <= PTR_RST;
    else if ((st_q == ST_RD) & ack & ~is_ret)
      dat_q <= pop_val;
    else if (wr_dat_lo)
      dat_q[31:0] <= pwdata;
    else if (wr_dat_hi)
      dat_q[63:32] <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      frame_base_q <= PTR_RST;
    else if (wr_fb_lo)
      frame_base_q[31:0] <= pwdata;
    else if (wr_fb_hi)
      frame_base_q[63:32] <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sel_q <= 16'h0;
    else if (go_ld)
      sel_q <= pwdata[CMD_SEL_LSB +: 16];
    else if (wr_sel)
      sel_q <= pwdata[15:0];
  end

  // Long mode overrides any software write of the privilege field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      desc_priv_q <= 2'h0;
    else if (ctl_q.lm)
      desc_priv_q <= ctl_q.cur_priv;
    else if (wr_sel)
      desc_priv_q <= pwdata[SEL_PRIV +: 2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      base_q <= 32'h0;
    else if (wr_base)
      base_q <= pwdata;
  end

  // Mode changes mid-sequence would corrupt the step, so held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctl_q <= spau_ctl_s'(CTRL_RST);
    else if (wr_ctrl & idle)
      ctl_q <= spau_ctl_s'(pwdata[5:0]);
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      inv_q <= 1'b0;
    else
      inv_q <= inv_set | (inv_q & ~(wr_stat & pwdata[STA_INV]));
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  push_order_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_DEC) |=> mem_q.req && mem_q.we &&
      (stk_ptr_q == $past(ptr_push)) && (st_q == ST_WR))
    else $error("push did not decrement before write");

  pop_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_RD) && ack && is_pop |=> (st_q == ST_INC) ##1
      (stk_ptr_q != $past(stk_ptr_q, 2)) || (step == 64'h0))
    else $error("pop did not increment after read");

  seg_align_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_DEC) && is_seg && !ctl_q.lm && ctl_q.code_d
      |=> (stk_ptr_q[1:0] == 2'h0))
    else $error("selector push left pointer unaligned");

  slot64_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_DEC) && is_seg && ctl_q.lm
      |=> (stk_ptr_q[2:0] == 3'h0) && (mem_q.nbytes == 4'h8))
    else $error("long mode selector push not in full slot");

  no_fault_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && !ctl_q.lm |=> !$rose(inv_q))
    else $error("fault raised outside long mode");

  upper_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((st_q == ST_DEC) || (st_q == ST_INC)) && !ctl_q.lm &&
      !ctl_q.ss_big |=> $stable(stk_ptr_q[63:16]))
    else $error("upper pointer bits changed in 16-bit mode");

  zero_base_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_DEC) && ctl_q.lm |=> (mem_q.addr == stk_ptr_q))
    else $error("long mode address used a segment base");

  priv_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_q.lm ##1 ctl_q.lm |-> (desc_priv_q == $past(ctl_q.cur_priv)))
    else $error("descriptor privilege not forced in long mode");

  call_link_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_WR) && ack && is_call
      |-> (mem_q.wdata == instr_ptr_q) ##1 (instr_ptr_q == $past(dat_q)))
    else $error("call did not push return pointer first");

  ret_link_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_RD) && ack && is_ret |=> (instr_ptr_q == $past(pop_val))
      ##1 (st_q == ST_IDLE))
    else $error("return did not load instruction pointer");

  bad_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    inv_set |=> inv_q && (st_q == ST_IDLE) && !mem_q.req)
    else $error("invalid long mode load was executed");

  step_size_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_DEC) && !ctl_q.lm && !op16_q
      |=> (mem_q.nbytes == (ctl_q.code_d ? 4'h4 : 4'h2)))
    else $error("push step does not follow code default flag");

endmodule

// File: design/spau_pkg.sv
/*
  Shared constants and types of the stack pointer address unit.
  Assumes a 32-bit APB master and a 64-bit wide stack memory port.
*/
package spau_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_PTR_LO = 8'h0c;
  localparam logic [7:0] OFS_PTR_HI = 8'h10;
  localparam logic [7:0] OFS_IP_LO = 8'h14;
  localparam logic [7:0] OFS_IP_HI = 8'h18;
  localparam logic [7:0] OFS_FB_LO = 8'h1c;
  localparam logic [7:0] OFS_FB_HI = 8'h20;
  localparam logic [7:0] OFS_DAT_LO = 8'h24;
  localparam logic [7:0] OFS_DAT_HI = 8'h28;
  localparam logic [7:0] OFS_SEL = 8'h2c;
  localparam logic [7:0] OFS_BASE = 8'h30;
  localparam logic [7:0] OFS_ADR = 8'h34;

  // Field positions
  localparam int CMD_OP_MSB = 3;
  localparam int CMD_OP16 = 4;
  localparam int CMD_SEL_LSB = 16;
  localparam int STA_BUSY = 0;
  localparam int STA_INV = 1;
  localparam int STA_EXP32 = 2;
  localparam int STA_PRIV = 3;
  localparam int SEL_PRIV = 16;

  // Reset values and step widths
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [63:0] PTR_RST = 64'h0;
  localparam logic [63:0] STEP_W = 64'h2;
  localparam logic [63:0] STEP_D = 64'h4;
  localparam logic [63:0] STEP_Q = 64'h8;

  typedef struct packed {
    logic [1:0] cur_priv;
    logic pfx;
    logic lm;
    logic ss_big;
    logic code_d;
  } spau_ctl_s;

  typedef enum logic [3:0] {
    OP_NONE, OP_PUSH, OP_POP, OP_PUSH_SEG, OP_CALL, OP_RET,
    OP_LD_FAR_STACK, OP_LD_FAR_DATA, OP_POP_EXTRA, OP_FRAME_RD,
    OP_PTR_RD
  } spau_op_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [3:0] nbytes;
    logic [63:0] addr;
    logic [63:0] wdata;
  } spau_mem_s;

endpackage

// File: tb/spau_mem_model.sv
/*
  Behavioural stack memory facing the stack pointer address unit.
  Assumes the unit holds its request until the acknowledge pulse and
  drops it the cycle after; lat sets the wait before each answer.
*/
`timescale 1ns/1ns

module spau_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stack memory port
  input wire spau_pkg::spau_mem_s mem_req,
  output logic [63:0] mem_rdata,
  output logic mem_ack,
  // Bench control
  input wire logic [7:0] lat
);
  import spau_pkg::*;

  logic [7:0] bytes_q [logic [63:0]];
  logic [7:0] wait_q;

  function automatic logic [63:0] peek(input logic [63:0] a,
                                       input int n);
    logic [63:0] v;
    v = 64'h0;
    for (int i = 0; i < n; i++) begin
      v[8*i +: 8] = bytes_q.exists(a + 64'(i)) ? bytes_q[a + 64'(i)] : 8'hxx;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 64'h0;
      wait_q <= 8'h0;
    end else begin
      mem_ack <= 1'b0;
      // Toggle so stale read data never looks valid
      mem_rdata <= ~mem_rdata;
      if (mem_req.req && !mem_ack) begin
        if (wait_q == lat) begin
          wait_q <= 8'h0;
          mem_ack <= 1'b1;
          if (mem_req.we) begin
            for (int i = 0; i < 8; i++) begin
              if (i < int'(mem_req.nbytes)) begin
                bytes_q[mem_req.addr + 64'(i)] = mem_req.wdata[8*i +: 8];
              end
            end
          end else begin
            mem_rdata <= peek(mem_req.addr, int'(mem_req.nbytes));
          end
        end else begin
          wait_q <= wait_q + 8'h1;
        end
      end
    end
  end
endmodule

// File: tb/spau_core_tb.sv
/*
  Self-checking bench for the stack pointer address unit.
  Assumes the APB map and command codes of the design package.
*/
`timescale 1ns/1ns

module spau_core_tb;
  import spau_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic mem_ack, last_err;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata;
  logic [63:0] mem_rdata;
  spau_mem_s mem_req;
  int num_errors, samples_checked, cycles;

  spau_core u_spau_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  spau_mem_model u_spau_mem_model (.pclk(pclk), .presetn(presetn),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .lat(lat));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Mismatches %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench ceiling ends this wait
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Slave answers in the first access cycle
    chk("pready wait", 64'h1, 64'(n));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string name);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(name, {32'h0, e}, {32'h0, q});
  endtask

  task automatic wr64(input logic [7:0] a, input logic [63:0] d);
    wr(a, d[31:0]);
    wr(a + 8'h4, d[63:32]);
  endtask

  task automatic rd64(input logic [7:0] a, input logic [63:0] e,
                      input string name);
    logic [31:0] lo, hi;
    apb(1'b0, a, 32'h0, lo);
    apb(1'b0, a + 8'h4, 32'h0, hi);
    chk(name, e, {hi, lo});
  endtask

  task automatic wait_idle();
    logic [31:0] q;
    int n;
    for (n = 0; n < 200; n++) begin
      apb(1'b0, OFS_STAT, 32'h0, q);
      if (q[STA_BUSY] === 1'b0) break;
    end
    if (n == 200) begin
      chk("busy", 64'h0, 64'h1);
      summarize();
    end
  endtask

  task automatic cmd(input logic [31:0] v);
    wr(OFS_CMD, v);
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lat = 8'h2;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h0, "ctrl reset");
    rd(OFS_STAT, 32'h0, "stat reset");
    rd(OFS_PTR_LO, 32'h0, "ptr reset");
    rd(8'h38, 32'h0, "unmapped data");
    chk("unmapped err", 64'h1, {63'h0, last_err});
    // 16-bit stack, base applied to a 16-bit offset
    wr(OFS_BASE, 32'h1000);
    wr64(OFS_PTR_LO, 64'habcd0010);
    wr64(OFS_DAT_LO, 64'h1234);
    cmd(32'h1);
    rd(OFS_PTR_LO, 32'habcd000e, "push16 ptr");
    rd(OFS_ADR, 32'h100e, "push16 adr");
    chk("push16 mem", 64'h1234,
        u_spau_mem_model.peek(64'h100e, 2));
    wr64(OFS_DAT_LO, 64'h0);
    cmd(32'h2);
    rd(OFS_DAT_LO, 32'h1234, "pop16 data");
    rd(OFS_PTR_LO, 32'habcd0010, "pop16 ptr");
    wr(OFS_PTR_LO, 32'habcd0000);
    cmd(32'h1);
    rd(OFS_PTR_LO, 32'habcdfffe, "wrap16 ptr");
    rd(OFS_ADR, 32'h10ffe, "wrap16 adr");
    // 32-bit stack
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 32'h2 | 32'(i[0]) | (32'(i[1]) << 3));
      rd(OFS_STAT, 32'(i[0] ^ i[1]) << 2, "explicit size");
    end
    wr(OFS_CTRL, 32'h3);
    wr64(OFS_PTR_LO, 64'h100);
    wr64(OFS_DAT_LO, 64'h11223344);
    cmd(32'h1);
    rd(OFS_PTR_LO, 32'hfc, "push32 ptr");
    rd(OFS_ADR, 32'h10fc, "push32 adr");
    chk("push32 mem", 64'h11223344,
        u_spau_mem_model.peek(64'h10fc, 4));
    cmd(32'h11);
    rd(OFS_PTR_LO, 32'hfa, "op16 ptr");
    chk("op16 mem", 64'h3344, u_spau_mem_model.peek(64'h10fa, 2));
    cmd(32'h3);
    rd(OFS_PTR_LO, 32'hf4, "selpush ptr");
    rd(OFS_STAT, 32'h4, "no fault");
    wr64(OFS_PTR_LO, 64'h5_00000000);
    cmd(32'h1);
    rd64(OFS_PTR_LO, 64'h5_fffffffc, "wrap32 ptr");
    rd(OFS_ADR, 32'hffc, "wrap32 adr");
    // Call and return linking, frame read and far load
    wr64(OFS_PTR_LO, 64'h200);
    wr64(OFS_IP_LO, 64'h5000);
    wr64(OFS_DAT_LO, 64'h9000);
    cmd(32'h4);
    chk("call mem", 64'h5000, u_spau_mem_model.peek(64'h11fc, 4));
    rd(OFS_IP_LO, 32'h9000, "call ip");
    cmd(32'h5);
    rd(OFS_IP_LO, 32'h5000, "ret ip");
    rd(OFS_PTR_LO, 32'h200, "ret ptr");
    wr64(OFS_DAT_LO, 64'hdead0000);
    cmd(32'h1);
    cmd(32'h5);
    rd(OFS_IP_LO, 32'hdead0000, "forged ret");
    wr64(OFS_FB_LO, 64'h1fc);
    wr64(OFS_DAT_LO, 64'h0);
    cmd(32'h9);
    rd(OFS_DAT_LO, 32'hdead0000, "frame read");
    wr64(OFS_DAT_LO, 64'h300);
    cmd(32'h00770006);
    rd(OFS_SEL, 32'h77, "far load sel");
    rd(OFS_PTR_LO, 32'h300, "far load ptr");
    // 64-bit mode, privilege 2, nonzero base still programmed
    wr(OFS_CTRL, 32'h27);
    rd(OFS_SEL, 32'h20077, "sel priv");
    rd(OFS_STAT, 32'h14, "stat priv");
    wr64(OFS_PTR_LO, 64'h1_00000100);
    wr64(OFS_DAT_LO, 64'h0102030405060708);
    cmd(32'h1);
    rd64(OFS_PTR_LO, 64'h1_000000f8, "push64 ptr");
    rd(OFS_ADR, 32'hf8, "push64 adr");
    chk("push64 mem", 64'h0102030405060708,
        u_spau_mem_model.peek(64'h1_000000f8, 8));
    wr64(OFS_DAT_LO, 64'h0);
    cmd(32'ha);
    rd64(OFS_DAT_LO, 64'h0102030405060708, "ptr read");
    rd64(OFS_PTR_LO, 64'h1_000000f8, "ptr read ptr");
    wr64(OFS_DAT_LO, 64'h0);
    cmd(32'h2);
    rd64(OFS_DAT_LO, 64'h0102030405060708, "pop64 data");
    rd64(OFS_PTR_LO, 64'h1_00000100, "pop64 ptr");
    wr(OFS_PTR_LO, 32'hf5);
    cmd(32'h3);
    rd64(OFS_PTR_LO, 64'h1_000000e8, "selpush64");
    cmd(32'h7);
    rd(OFS_STAT, 32'h16, "far data inv");
    wr(OFS_STAT, 32'h2);
    rd(OFS_STAT, 32'h14, "inv clear");
    cmd(32'h8);
    rd(OFS_STAT, 32'h16, "pop extra inv");
    wr(OFS_STAT, 32'h2);
    // Slow memory: pointer writes while busy are dropped
    wr(OFS_PTR_LO, 32'h100);
    lat <= 8'd20;
    wr(OFS_CMD, 32'h1);
    rd(OFS_STAT, 32'h15, "busy stat");
    wr(OFS_PTR_LO, 32'h777);
    wait_idle();
    rd(OFS_PTR_LO, 32'hf8, "busy write");
    summarize();
  end
endmodule
